// ---- pkg/ntps_map.svh ----
`ifndef NTPS_MAP_SVH
`define NTPS_MAP_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define NTPS_CMD_CONFIRM_END 8'h10
`define NTPS_CMD_CONFIRM_ILV 8'h11
`define NTPS_CMD_CONFIRM_CACHE 8'h15
`define NTPS_CMD_COL_CHANGE 8'h85
`define NTPS_CMD_PROGRAM 8'h80
`define NTPS_CMD_CHG_RD_COL 8'h05
`define NTPS_CMD_CHG_RD_COL_ENH 8'h06
`define NTPS_CMD_RD_STATUS 8'h70
`define NTPS_CMD_RD_STATUS_ENH 8'h78

// ----------------------------------------------------------------------
// Address geometry
// ----------------------------------------------------------------------
`define NTPS_COL_CYCLES 2
`define NTPS_ROW_CYCLES 3
`define NTPS_UNIT_LSB 21
`define NTPS_UNIT_MSB 23

// ----------------------------------------------------------------------
// Data buffer
// ----------------------------------------------------------------------
`define NTPS_FIFO_DEPTH 32
`define NTPS_BYTE_W 8

`endif

// ---- pkg/ntps_pkg.sv ----
package ntps_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_PROGRAM_DATA_WAIT = 4'h1,
    ST_PROGRAM_DATA_FORWARD = 4'h2,
    ST_PROGRAM_COMMAND_FORWARD = 4'h3,
    ST_INTERLEAVED_PROGRAM_WAIT = 4'h4,
    ST_COLUMN_CHANGE_WAIT = 4'h5,
    ST_COLUMN_CHANGE_COLLECT = 4'h6,
    ST_COLUMN_CHANGE_REQUEST = 4'h7,
    ST_POST_COLUMN_CHANGE_WAIT = 4'h8,
    ST_ROW_CHANGE_COLLECT = 4'h9,
    ST_ROW_CHANGE_WAIT = 4'hA,
    ST_ROW_CHANGE_REQUEST = 4'hB
  } ntps_state_type;

  typedef enum logic [1:0] {
    KIND_COMMAND = 2'h0,
    KIND_ADDRESS = 2'h1,
    KIND_DATA = 2'h2,
    KIND_READ = 2'h3
  } ntps_kind_type;

  typedef enum logic [2:0] {
    EXIT_NONE = 3'h0,
    EXIT_PROGRAM_ADDRESS_WAIT = 3'h1,
    EXIT_CHANGE_READ_COLUMN_START = 3'h2,
    EXIT_ENHANCED_CHANGE_READ_COLUMN_START = 3'h3,
    EXIT_READ_STATUS_START = 3'h4,
    EXIT_READ_STATUS_ENHANCED_START = 3'h5,
    EXIT_STATUS_DATA = 3'h6
  } ntps_exit_type;

endpackage

// ---- hdl/ntps_fifo.sv ----
`timescale 1ns/10ps
module ntps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_ptr_reg;
  logic [PW:0] rd_ptr_reg;
  logic full;
  logic empty;

  assign full = (wr_ptr_reg[PW] != rd_ptr_reg[PW]) && (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]);
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_ptr_reg[PW-1:0]];

  always_ff @(posedge core_clk_i) begin
    if (in_valid_i && !full) begin
      mem[wr_ptr_reg[PW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
    end else if (in_valid_i && !full) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rd_ptr_reg <= '0;
    end else if (out_ready_i && !empty) begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule

// ---- hdl/ntps_cycle_store.sv ----
`timescale 1ns/10ps
module ntps_cycle_store #(
  parameter int CYCLES = 2
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic [7:0] byte_i,
  // Result
  output logic [CYCLES*8-1:0] value_o,
  output logic complete_o
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count_reg;
  logic [CW-1:0] base;

  // A clear together with a load starts a fresh address with this byte.
  assign base = clear_i ? '0 : count_reg;
  assign complete_o = (count_reg == CW'(CYCLES));

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      count_reg <= '0;
    end else if (load_i) begin
      count_reg <= base + 1'b1;
    end else if (clear_i) begin
      count_reg <= '0;
    end
  end

  // First cycle received is the least significant byte.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      value_o <= '0;
    end else if (load_i && base < CW'(CYCLES)) begin
      value_o[base*8 +: 8] <= byte_i;
    end
  end
endmodule

// ---- hdl/ntps_sequencer.sv ----
`timescale 1ns/10ps
`include "ntps_map.svh"

module ntps_sequencer
  import ntps_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Program issue from the setup logic
  input wire logic program_issue_i,
  input wire logic [`NTPS_ROW_CYCLES*8-1:0] issue_row_i,
  // Target flags
  input wire logic copy_through_flag_i,
  input wire logic status_output_flag_i,
  // Host cycles
  input wire logic host_valid_i,
  input wire ntps_kind_type host_kind_i,
  input wire logic [7:0] host_byte_i,
  output logic host_ready_o,
  // Unit data stream
  output logic lun_data_valid_o,
  output logic [7:0] lun_data_o,
  input wire logic lun_data_ready_i,
  // Unit requests
  output logic [`NTPS_UNIT_MSB-`NTPS_UNIT_LSB:0] selected_unit_o,
  output logic lun_cmd_valid_o,
  output logic [7:0] lun_cmd_o,
  output logic lun_col_chg_o,
  output logic [`NTPS_COL_CYCLES*8-1:0] lun_col_addr_o,
  output logic lun_row_chg_o,
  output logic [`NTPS_ROW_CYCLES*8-1:0] lun_row_addr_o,
  // Hand-off to the rest of the target
  output logic exit_valid_o,
  output ntps_exit_type exit_code_o,
  output ntps_state_type resume_state_o,
  output logic busy_o
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  ntps_state_type state_reg;
  ntps_state_type state_next;
  ntps_exit_type exit_next;
  logic waiting;
  logic accept;
  logic is_cmd;
  logic is_addr;
  logic is_data;
  logic is_read;
  logic confirm_ok;
  logic fifo_in_ready;
  logic fifo_push;
  logic fifo_empty;
  logic col_clear;
  logic col_load;
  logic col_complete;
  logic row_clear;
  logic row_load;
  logic row_complete;
  logic [7:0] cmd_reg;

  // --------------------------------------------------------------------
  // Host cycle acceptance
  // --------------------------------------------------------------------
  assign waiting = (state_reg == ST_PROGRAM_DATA_WAIT) ||
                   (state_reg == ST_INTERLEAVED_PROGRAM_WAIT) ||
                   (state_reg == ST_COLUMN_CHANGE_WAIT) ||
                   (state_reg == ST_POST_COLUMN_CHANGE_WAIT) ||
                   (state_reg == ST_ROW_CHANGE_WAIT);
  // Data is held off while the buffer toward the unit is full.
  assign host_ready_o = waiting && ((host_kind_i != KIND_DATA) || fifo_in_ready);
  assign accept = host_valid_i && host_ready_o;
  assign is_cmd = accept && (host_kind_i == KIND_COMMAND);
  assign is_addr = accept && (host_kind_i == KIND_ADDRESS);
  assign is_data = accept && (host_kind_i == KIND_DATA);
  assign is_read = accept && (host_kind_i == KIND_READ);
  assign busy_o = (state_reg != ST_IDLE);

  // Confirm set shared by data-wait and post-column wait.
  assign confirm_ok = ((host_byte_i == `NTPS_CMD_CONFIRM_CACHE) && !copy_through_flag_i) ||
                      (host_byte_i == `NTPS_CMD_CONFIRM_END) ||
                      (host_byte_i == `NTPS_CMD_CONFIRM_ILV);

  // --------------------------------------------------------------------
  // Data path toward the unit
  // --------------------------------------------------------------------
  assign fifo_push = is_data && ((state_reg == ST_PROGRAM_DATA_WAIT) ||
                                 (state_reg == ST_POST_COLUMN_CHANGE_WAIT));

  ntps_fifo #(
    .WIDTH(`NTPS_BYTE_W),
    .DEPTH(`NTPS_FIFO_DEPTH)
  ) u_data_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(fifo_push),
    .in_data_i(host_byte_i),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(lun_data_valid_o),
    .out_data_o(lun_data_o),
    .out_ready_i(lun_data_ready_i)
  );
  assign fifo_empty = !lun_data_valid_o;

  // --------------------------------------------------------------------
  // Address collection
  // --------------------------------------------------------------------
  assign col_clear = is_cmd && (host_byte_i == `NTPS_CMD_COL_CHANGE) &&
                     ((state_reg == ST_PROGRAM_DATA_WAIT) ||
                      (state_reg == ST_POST_COLUMN_CHANGE_WAIT));
  assign col_load = is_addr && (state_reg == ST_COLUMN_CHANGE_WAIT);
  assign row_clear = is_addr && (state_reg == ST_POST_COLUMN_CHANGE_WAIT);
  assign row_load = is_addr && ((state_reg == ST_POST_COLUMN_CHANGE_WAIT) ||
                                (state_reg == ST_ROW_CHANGE_WAIT));

  ntps_cycle_store #(
    .CYCLES(`NTPS_COL_CYCLES)
  ) u_col_store (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(col_clear),
    .load_i(col_load),
    .byte_i(host_byte_i),
    .value_o(lun_col_addr_o),
    .complete_o(col_complete)
  );

  ntps_cycle_store #(
    .CYCLES(`NTPS_ROW_CYCLES)
  ) u_row_store (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(row_clear),
    .load_i(row_load),
    .byte_i(host_byte_i),
    .value_o(lun_row_addr_o),
    .complete_o(row_complete)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    exit_next = EXIT_NONE;
    case (state_reg)
      ST_IDLE: begin
        if (program_issue_i) begin
          state_next = ST_PROGRAM_DATA_WAIT;
        end
      end
      ST_PROGRAM_DATA_WAIT, ST_POST_COLUMN_CHANGE_WAIT: begin
        if (fifo_push) begin
          state_next = ST_PROGRAM_DATA_FORWARD;
        end else if (is_cmd && confirm_ok) begin
          state_next = ST_PROGRAM_COMMAND_FORWARD;
        end else if (col_clear) begin
          state_next = ST_COLUMN_CHANGE_WAIT;
        end else if (row_load) begin
          state_next = ST_ROW_CHANGE_COLLECT;
        end
      end
      ST_PROGRAM_DATA_FORWARD: begin
        state_next = ST_PROGRAM_DATA_WAIT;
      end
      ST_PROGRAM_COMMAND_FORWARD: begin
        // Buffered data reaches the unit before its confirm does.
        if (fifo_empty) begin
          if (cmd_reg == `NTPS_CMD_CONFIRM_ILV) begin
            state_next = ST_INTERLEAVED_PROGRAM_WAIT;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_INTERLEAVED_PROGRAM_WAIT: begin
        if (is_cmd) begin
          case (host_byte_i)
            `NTPS_CMD_COL_CHANGE: exit_next = EXIT_PROGRAM_ADDRESS_WAIT;
            `NTPS_CMD_PROGRAM: begin
              if (!copy_through_flag_i) begin
                exit_next = EXIT_PROGRAM_ADDRESS_WAIT;
              end
            end
            `NTPS_CMD_CHG_RD_COL: exit_next = EXIT_CHANGE_READ_COLUMN_START;
            `NTPS_CMD_CHG_RD_COL_ENH: exit_next = EXIT_ENHANCED_CHANGE_READ_COLUMN_START;
            `NTPS_CMD_RD_STATUS: exit_next = EXIT_READ_STATUS_START;
            `NTPS_CMD_RD_STATUS_ENH: exit_next = EXIT_READ_STATUS_ENHANCED_START;
            default: exit_next = EXIT_NONE;
          endcase
        end else if (is_read && status_output_flag_i) begin
          exit_next = EXIT_STATUS_DATA;
        end
        if (exit_next != EXIT_NONE) begin
          state_next = ST_IDLE;
        end
      end
      ST_COLUMN_CHANGE_WAIT: begin
        if (col_load) begin
          state_next = ST_COLUMN_CHANGE_COLLECT;
        end
      end
      ST_COLUMN_CHANGE_COLLECT: begin
        state_next = col_complete ? ST_COLUMN_CHANGE_REQUEST : ST_COLUMN_CHANGE_WAIT;
      end
      ST_COLUMN_CHANGE_REQUEST: begin
        if (fifo_empty) begin
          state_next = ST_POST_COLUMN_CHANGE_WAIT;
        end
      end
      ST_ROW_CHANGE_COLLECT: begin
        state_next = row_complete ? ST_ROW_CHANGE_REQUEST : ST_ROW_CHANGE_WAIT;
      end
      ST_ROW_CHANGE_WAIT: begin
        if (row_load) begin
          state_next = ST_ROW_CHANGE_COLLECT;
        end
      end
      ST_ROW_CHANGE_REQUEST: begin
        if (fifo_empty) begin
          state_next = ST_PROGRAM_DATA_WAIT;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // State and registered outputs
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cmd_reg <= 8'h00;
    end else if (is_cmd) begin
      cmd_reg <= host_byte_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      selected_unit_o <= '0;
    end else if (state_reg == ST_IDLE && program_issue_i) begin
      selected_unit_o <= issue_row_i[`NTPS_UNIT_MSB:`NTPS_UNIT_LSB];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      resume_state_o <= ST_IDLE;
    end else if (state_next == ST_INTERLEAVED_PROGRAM_WAIT &&
                 state_reg != ST_INTERLEAVED_PROGRAM_WAIT) begin
      resume_state_o <= ST_INTERLEAVED_PROGRAM_WAIT;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      lun_cmd_valid_o <= 1'b0;
      lun_cmd_o <= 8'h00;
    end else begin
      lun_cmd_valid_o <= (state_reg == ST_PROGRAM_COMMAND_FORWARD) && fifo_empty;
      lun_cmd_o <= cmd_reg;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      lun_col_chg_o <= 1'b0;
      lun_row_chg_o <= 1'b0;
    end else begin
      lun_col_chg_o <= (state_reg == ST_COLUMN_CHANGE_REQUEST) && fifo_empty;
      lun_row_chg_o <= (state_reg == ST_ROW_CHANGE_REQUEST) && fifo_empty;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      exit_valid_o <= 1'b0;
      exit_code_o <= EXIT_NONE;
    end else begin
      exit_valid_o <= (exit_next != EXIT_NONE);
      exit_code_o <= exit_next;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_col_done;
    (state_reg == ST_COLUMN_CHANGE_COLLECT) && col_complete;
  endsequence

  // The request pulse and the move to the post-column wait share one edge.
  sequence s_col_request;
    (state_reg == ST_COLUMN_CHANGE_REQUEST) ##[1:40]
    (lun_col_chg_o && (state_reg == ST_POST_COLUMN_CHANGE_WAIT));
  endsequence

  a_data_wait_push: assert property (
    (state_reg == ST_PROGRAM_DATA_WAIT) && is_data |-> fifo_push ##1
    (state_reg == ST_PROGRAM_DATA_FORWARD) ##1 (state_reg == ST_PROGRAM_DATA_WAIT))
    else $error("Data in data-wait not buffered and returned.");

  a_cache_blocked: assert property (
    (state_reg == ST_PROGRAM_DATA_WAIT) && is_cmd && copy_through_flag_i &&
    (host_byte_i == 8'h15) |=> (state_reg == ST_PROGRAM_DATA_WAIT) && !lun_cmd_valid_o)
    else $error("15h taken while copy-through set.");

  a_confirm_taken: assert property (
    (state_reg == ST_PROGRAM_DATA_WAIT) && is_cmd &&
    (host_byte_i == 8'h10 || host_byte_i == 8'h11) |=> state_reg == ST_PROGRAM_COMMAND_FORWARD)
    else $error("Confirm not moved to command forwarding.");

  a_confirm_route: assert property (
    lun_cmd_valid_o |-> (lun_cmd_o == 8'h11) == (state_reg == ST_INTERLEAVED_PROGRAM_WAIT))
    else $error("Confirm led to the wrong state.");

  a_resume_mark: assert property (
    state_reg == ST_INTERLEAVED_PROGRAM_WAIT |-> resume_state_o == ST_INTERLEAVED_PROGRAM_WAIT)
    else $error("Resume state not recorded.");

  a_ilv_program: assert property (
    (state_reg == ST_INTERLEAVED_PROGRAM_WAIT) && is_cmd && (host_byte_i == 8'h80) |=>
    exit_valid_o == !$past(copy_through_flag_i))
    else $error("80h exit does not follow copy-through.");

  a_status_exit: assert property (
    (state_reg == ST_INTERLEAVED_PROGRAM_WAIT) && is_read && status_output_flag_i |=>
    exit_valid_o && exit_code_o == EXIT_STATUS_DATA && state_reg == ST_IDLE)
    else $error("Status read did not exit.");

  a_col_request: assert property (
    s_col_done |=> s_col_request)
    else $error("Column change not requested after collection.");

  a_row_return: assert property (
    lun_row_chg_o |-> state_reg == ST_PROGRAM_DATA_WAIT && row_complete)
    else $error("Row change did not return to data-wait.");

  a_unit_load: assert property (
    (state_reg == ST_IDLE) && program_issue_i |=>
    selected_unit_o == $past(issue_row_i[`NTPS_UNIT_MSB:`NTPS_UNIT_LSB]))
    else $error("Selected unit not loaded from row address.");

  a_unlisted_cmd: assert property (
    (state_reg == ST_INTERLEAVED_PROGRAM_WAIT) && is_cmd && (host_byte_i == 8'h30) |=>
    state_reg == ST_INTERLEAVED_PROGRAM_WAIT && !exit_valid_o)
    else $error("Unlisted command changed state.");
endmodule

// ---- verif/ntps_host_model.sv ----
`timescale 1ns/10ps
module ntps_host_model
  import ntps_pkg::*;
(
  // Clock and handshake
  input wire logic core_clk_i,
  input wire logic host_ready_i,
  // Host cycles
  output logic host_valid_o,
  output ntps_kind_type host_kind_o,
  output logic [7:0] host_byte_o
);
  initial begin
    host_valid_o = 1'b0;
    host_kind_o = KIND_COMMAND;
    host_byte_o = 8'h00;
  end

  // ----------------------------------------------------------------------
  // Cycle offer
  // ----------------------------------------------------------------------
  // Address bytes are passed through as the caller gives them, so a caller
  // repeating unit, page and interleave fields keeps them unchanged.
  task automatic send(input ntps_kind_type kind, input logic [7:0] value,
                      input int patience, output logic taken);
    int n;
    taken = 1'b0;
    @(posedge core_clk_i);
    #1;
    host_valid_o = 1'b1;
    host_kind_o = kind;
    host_byte_o = value;
    for (n = 0; n < patience && !taken; n++) begin
      @(negedge core_clk_i);
      if (host_ready_i === 1'b1) begin
        taken = 1'b1;
      end
      @(posedge core_clk_i);
    end
    #1;
    // A released bus shows the inverse so a stale byte is never mistaken for data.
    host_valid_o = 1'b0;
    host_byte_o = ~value;
  endtask
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module tb_top
  import ntps_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic program_issue = 1'b0;
  logic [23:0] issue_row = 24'h000000;
  logic copy_flag = 1'b0;
  logic status_flag = 1'b0;
  logic lun_data_ready = 1'b1;
  logic host_valid, host_ready, lun_data_valid, lun_cmd_valid, col_chg, row_chg;
  logic exit_valid, busy, t;
  ntps_kind_type host_kind;
  logic [7:0] host_byte, lun_data, lun_cmd;
  logic [2:0] selected_unit;
  logic [15:0] col_addr;
  logic [23:0] row_addr;
  ntps_exit_type exit_code;
  ntps_exit_type last_exit = EXIT_NONE;
  ntps_state_type resume_state;
  int mismatches = 0;
  int cmp_count = 0;
  int n_cmd = 0;
  int n_col = 0;
  int n_row = 0;
  int n_exit = 0;
  logic [7:0] data_q[$];

  always #50 core_clk_i = ~core_clk_i;

  ntps_host_model i_ntps_host_model (.core_clk_i(core_clk_i), .host_ready_i(host_ready),
    .host_valid_o(host_valid), .host_kind_o(host_kind), .host_byte_o(host_byte));

  ntps_sequencer i_ntps_sequencer (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .program_issue_i(program_issue), .issue_row_i(issue_row),
    .copy_through_flag_i(copy_flag), .status_output_flag_i(status_flag),
    .host_valid_i(host_valid), .host_kind_i(host_kind), .host_byte_i(host_byte),
    .host_ready_o(host_ready), .lun_data_valid_o(lun_data_valid), .lun_data_o(lun_data),
    .lun_data_ready_i(lun_data_ready), .selected_unit_o(selected_unit),
    .lun_cmd_valid_o(lun_cmd_valid), .lun_cmd_o(lun_cmd), .lun_col_chg_o(col_chg),
    .lun_col_addr_o(col_addr), .lun_row_chg_o(row_chg), .lun_row_addr_o(row_addr),
    .exit_valid_o(exit_valid), .exit_code_o(exit_code), .resume_state_o(resume_state),
    .busy_o(busy));

  // ----------------------------------------------------------------------
  // Unit side monitor
  // ----------------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (lun_cmd_valid === 1'b1) n_cmd++;
    if (col_chg === 1'b1) n_col++;
    if (row_chg === 1'b1) n_row++;
    if (exit_valid === 1'b1) begin
      n_exit++;
      last_exit = exit_code;
    end
    if (lun_data_valid === 1'b1 && lun_data_ready) data_q.push_back(lun_data);
  end

  // ----------------------------------------------------------------------
  // Shared steps
  // ----------------------------------------------------------------------
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic put(input ntps_kind_type k, input logic [7:0] b);
    i_ntps_host_model.send(k, b, 40, t);
    `CHK("taken", 1'b1, t)
  endtask

  task automatic start(input logic [2:0] unit);
    @(posedge core_clk_i);
    #1;
    program_issue = 1'b1;
    issue_row = {unit, 21'h01234};
    @(posedge core_clk_i);
    #1;
    program_issue = 1'b0;
    settle(2);
    `CHK("selected_unit", unit, selected_unit)
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    `CHK("busy", 1'b0, busy)
    `CHK("host_ready", 1'b0, host_ready)
    `CHK("exit_valid", 1'b0, exit_valid)
  endtask

  task automatic t_fifo;
    int i;
    lun_data_ready = 1'b0;
    data_q.delete();
    start(3'h5);
    for (i = 0; i < `NTPS_FIFO_DEPTH; i++) put(KIND_DATA, 8'hA0 + i[7:0]);
    i_ntps_host_model.send(KIND_DATA, 8'hEE, 4, t);
    `CHK("full_refuse", 1'b0, t)
    lun_data_ready = 1'b1;
    settle(40);
    `CHK("drained", 32, data_q.size())
    for (i = 0; i < `NTPS_FIFO_DEPTH; i++) `CHK("data", 8'hA0 + i[7:0], data_q[i])
    put(KIND_COMMAND, `NTPS_CMD_CONFIRM_ILV);
    settle(4);
    `CHK("cmd_count", 1, n_cmd)
    `CHK("lun_cmd", 8'h11, lun_cmd)
    `CHK("resume", ST_INTERLEAVED_PROGRAM_WAIT, resume_state)
    put(KIND_COMMAND, 8'h70);
  endtask

  task automatic t_exits;
    logic [7:0] cmd [7] = '{8'h85, 8'h80, 8'h05, 8'h06, 8'h70, 8'h78, 8'h00};
    ntps_exit_type ex [7] = '{EXIT_PROGRAM_ADDRESS_WAIT, EXIT_PROGRAM_ADDRESS_WAIT,
      EXIT_CHANGE_READ_COLUMN_START, EXIT_ENHANCED_CHANGE_READ_COLUMN_START,
      EXIT_READ_STATUS_START, EXIT_READ_STATUS_ENHANCED_START, EXIT_STATUS_DATA};
    int i, e;
    for (i = 0; i < 7; i++) begin
      start(3'h2);
      put(KIND_COMMAND, 8'h11);
      settle(3);
      e = n_exit;
      if (i == 0) begin
        put(KIND_COMMAND, 8'h30);
        copy_flag = 1'b1;
        put(KIND_COMMAND, 8'h80);
        put(KIND_READ, 8'h00);
        copy_flag = 1'b0;
        settle(3);
        `CHK("ignored", e, n_exit)
        `CHK("busy_kept", 1'b1, busy)
      end
      status_flag = (i == 6);
      put((i == 6) ? KIND_READ : KIND_COMMAND, cmd[i]);
      settle(3);
      status_flag = 1'b0;
      `CHK("exit_count", e + 1, n_exit)
      `CHK("exit_code", ex[i], last_exit)
    end
  endtask

  task automatic t_confirm;
    int c;
    start(3'h1);
    c = n_cmd;
    copy_flag = 1'b1;
    put(KIND_COMMAND, `NTPS_CMD_CONFIRM_CACHE);
    settle(4);
    `CHK("cache_blocked", c, n_cmd)
    put(KIND_COMMAND, `NTPS_CMD_CONFIRM_END);
    settle(4);
    copy_flag = 1'b0;
    `CHK("end_cmd", 8'h10, lun_cmd)
    `CHK("end_idle", 1'b0, busy)
    start(3'h1);
    put(KIND_COMMAND, `NTPS_CMD_CONFIRM_CACHE);
    settle(4);
    `CHK("cache_count", c + 2, n_cmd)
    `CHK("cache_idle", 1'b0, busy)
  endtask

  task automatic t_colrow;
    start(3'h6);
    data_q.delete();
    put(KIND_COMMAND, `NTPS_CMD_COL_CHANGE);
    put(KIND_ADDRESS, 8'h34);
    settle(3);
    `CHK("col_partial", 0, n_col)
    put(KIND_ADDRESS, 8'h12);
    settle(4);
    `CHK("col_count", 1, n_col)
    `CHK("col_addr", 16'h1234, col_addr)
    put(KIND_COMMAND, `NTPS_CMD_COL_CHANGE);
    put(KIND_ADDRESS, 8'h78);
    put(KIND_ADDRESS, 8'h56);
    settle(4);
    `CHK("col_again", 16'h5678, col_addr)
    put(KIND_ADDRESS, 8'h34);
    put(KIND_ADDRESS, 8'h12);
    put(KIND_ADDRESS, 8'hC0);
    settle(4);
    `CHK("row_count", 1, n_row)
    `CHK("row_addr", 24'hC01234, row_addr)
    `CHK("row_unit", 3'h6, row_addr[23:21])
    put(KIND_COMMAND, `NTPS_CMD_COL_CHANGE);
    put(KIND_ADDRESS, 8'h9A);
    put(KIND_ADDRESS, 8'hBC);
    settle(4);
    `CHK("col_third", 3, n_col)
    `CHK("col_third_addr", 16'hBC9A, col_addr)
    put(KIND_DATA, 8'h5A);
    put(KIND_COMMAND, `NTPS_CMD_CONFIRM_END);
    settle(4);
    `CHK("post_col_data", 8'h5A, data_q[0])
    `CHK("row_idle", 1'b0, busy)
  endtask

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #(100 * 20000);
    mismatches++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    t_reset();
    t_fifo();
    t_exits();
    t_confirm();
    t_colrow();
    print_verdict();
  end
endmodule
